/* rtl/fp_err_pkg.sv */
// Constants for the floating-point error reporting unit: pin path and native trap path
package fp_err_pkg;
	localparam int FLAG_W = 6;
	localparam int ADDR_W = 8;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_EXC_MASK = 8'h04;
	localparam logic [7:0] OFS_FP_STATUS = 8'h08;
	localparam logic [7:0] OFS_FAULT_IP = 8'h0c;
	localparam logic [7:0] OFS_INT_STATUS = 8'h10;
	localparam logic [7:0] OFS_INT_MASK = 8'h14;
	// Control fields
	localparam int CTRL_NE_BIT = 0;
	localparam int CTRL_DEFER_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	// Status word: flags in low bits, summary above
	localparam int ES_BIT = 7;
	localparam logic [5:0] EXC_MASK_RESET = 6'h3f;
	// Interrupt status bits
	localparam int INT_W = 4;
	localparam int INT_EXC_BIT = 0;
	localparam int INT_PIN_BIT = 1;
	localparam int INT_IRQ_BIT = 2;
	localparam int INT_TRAP_BIT = 3;
	localparam logic [3:0] INT_MASK_RESET = 4'h0;
	// Internal exception vector for native mode
	localparam logic [7:0] FP_ERROR_VECTOR = 8'h10;
	// Instruction classes from the dispatch stage
	typedef enum logic [2:0] {
		CLS_OTHER = 3'h0,
		CLS_WAIT = 3'h1,
		CLS_FP_WAITING = 3'h2,
		CLS_SIMD = 3'h3,
		CLS_INIT_NOWAIT = 3'h4,
		CLS_CLEX_NOWAIT = 3'h5,
		CLS_STORE_NOWAIT = 3'h6,
		CLS_SAVE_NOWAIT = 3'h7
	} instr_class_t;
endpackage : fp_err_pkg

/* rtl/fp_err_signal.sv */
// Floating-point error reporting: pin path, native trap path, APB registers
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module fp_err_signal (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	// APB slave
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [fp_err_pkg::ADDR_W-1:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// Exception report from the arithmetic core
	input wire logic EXC_VALID_IN,
	input wire logic [fp_err_pkg::FLAG_W-1:0] EXC_FLAGS_IN,
	input wire logic [31:0] EXC_IP_IN,
	// Instruction dispatch
	input wire logic INSTR_VALID_IN,
	input wire logic [2:0] INSTR_CLASS_IN,
	input wire logic [31:0] INSTR_IP_IN,
	output logic INSTR_STALL_OUT,
	output logic TRAP_OUT,
	output logic [7:0] TRAP_VECTOR_OUT,
	output logic [31:0] TRAP_RETURN_IP_OUT,
	// Pins
	output logic FP_ERROR_OUT_N,
	input wire logic IGNORE_NUMERIC_ERROR_IN_N,
	input wire logic MASKABLE_IRQ_IN,
	output logic SINGLE_LP_ONLY_OUT,
	// Interrupt
	output logic IRQ_OUT
);
	import fp_err_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [1:0] ctrl_reg;
	logic [FLAG_W-1:0] exc_mask_reg;
	logic [FLAG_W-1:0] flags_reg;
	logic [FLAG_W-1:0] flags_next;
	logic [31:0] fault_ip_reg;
	logic [INT_W-1:0] int_status_reg;
	logic [INT_W-1:0] int_mask_reg;
	logic [INT_W-1:0] int_event;
	logic [31:0] prdata_reg;
	logic [1:0] pin_meta_reg;
	logic [1:0] pin_sync_reg;
	logic irq_seen_reg;
	logic err_reg;
	logic err_next;
	logic armed_reg;
	logic trap_reg;
	logic [31:0] ret_ip_reg;
	logic native;
	logic ignore;
	logic es;
	logic waits;
	logic clears;
	logic exc_unmasked;
	logic setup;
	logic wr_en;
	logic mapped;
	instr_class_t cls;

	assign cls = instr_class_t'(INSTR_CLASS_IN);
	assign native = ctrl_reg[CTRL_NE_BIT];
	assign es = |(flags_reg & ~exc_mask_reg);
	assign exc_unmasked = EXC_VALID_IN && |(EXC_FLAGS_IN & ~exc_mask_reg);
	// Only waiting classes look at pending exceptions
	assign waits = INSTR_VALID_IN && (cls == CLS_WAIT ||
		cls == CLS_FP_WAITING || cls == CLS_SIMD);
	// Init, clear and save discard pending exceptions without a check
	assign clears = INSTR_VALID_IN && (cls == CLS_INIT_NOWAIT ||
		cls == CLS_CLEX_NOWAIT || cls == CLS_SAVE_NOWAIT);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			pin_meta_reg <= 2'h1;
			pin_sync_reg <= 2'h1;
		end else begin
			pin_meta_reg <= {MASKABLE_IRQ_IN, IGNORE_NUMERIC_ERROR_IN_N};
			pin_sync_reg <= pin_meta_reg;
		end
	end
	// Ignore only matters on the pin path
	assign ignore = !pin_sync_reg[0] && !native;

	////////////////////////////////////////////////////////////////////////
	// Exception flags and faulting pointer
	always_comb begin
		flags_next = flags_reg;
		if (clears) begin
			flags_next = '0;
		end
		if (wr_en && PADDR_IN == OFS_FP_STATUS) begin
			flags_next = flags_next & ~PWDATA_IN[FLAG_W-1:0];
		end
		// Set wins over any clear in the same cycle
		if (EXC_VALID_IN) begin
			flags_next = flags_next | EXC_FLAGS_IN;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			flags_reg <= '0;
		end else begin
			flags_reg <= flags_next;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			fault_ip_reg <= 32'h0;
		end else if (exc_unmasked) begin
			fault_ip_reg <= EXC_IP_IN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Error pin, legacy mode only
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			armed_reg <= 1'b0;
		end else if (!es) begin
			armed_reg <= 1'b0;
		end else if (waits) begin
			armed_reg <= 1'b1;
		end
	end

	always_comb begin
		err_next = !native && es && !ignore;
		if (ctrl_reg[CTRL_DEFER_BIT] && !armed_reg && !waits) begin
			err_next = 1'b0;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			err_reg <= 1'b0;
		end else begin
			err_reg <= err_next;
		end
	end

	assign FP_ERROR_OUT_N = !err_reg;
	// Pin path serialises error ownership to one processor
	assign SINGLE_LP_ONLY_OUT = !native;

	////////////////////////////////////////////////////////////////////////
	// Freeze and native trap
	// Freeze holds until the handler clears flags or, in pin mode only, glue ignores errors
	assign INSTR_STALL_OUT = waits && es && (native || !ignore);

	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			trap_reg <= 1'b0;
			ret_ip_reg <= 32'h0;
		end else begin
			trap_reg <= waits && es && native && !trap_reg;
			if (waits && es && native && !trap_reg) begin
				ret_ip_reg <= INSTR_IP_IN;
			end
		end
	end

	assign TRAP_OUT = trap_reg;
	assign TRAP_VECTOR_OUT = FP_ERROR_VECTOR;
	assign TRAP_RETURN_IP_OUT = ret_ip_reg;

	////////////////////////////////////////////////////////////////////////
	// Interrupt status
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			irq_seen_reg <= 1'b0;
		end else begin
			irq_seen_reg <= pin_sync_reg[1];
		end
	end

	assign int_event[INT_EXC_BIT] = exc_unmasked;
	assign int_event[INT_PIN_BIT] = err_next && !err_reg;
	assign int_event[INT_IRQ_BIT] = pin_sync_reg[1] && !irq_seen_reg;
	assign int_event[INT_TRAP_BIT] = trap_reg;

	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			int_status_reg <= '0;
		end else if (wr_en && PADDR_IN == OFS_INT_STATUS) begin
			int_status_reg <= (int_status_reg & ~PWDATA_IN[INT_W-1:0]) |
				int_event;
		end else begin
			int_status_reg <= int_status_reg | int_event;
		end
	end

	assign IRQ_OUT = |(int_status_reg & int_mask_reg);

	////////////////////////////////////////////////////////////////////////
	// APB slave, zero wait states
	assign setup = PSEL_IN && !PENABLE_IN;
	assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN;
	assign mapped = PADDR_IN inside {OFS_CTRL, OFS_EXC_MASK, OFS_FP_STATUS,
		OFS_FAULT_IP, OFS_INT_STATUS, OFS_INT_MASK};
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;
	assign PRDATA_OUT = prdata_reg;

	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			ctrl_reg <= CTRL_RESET;
			exc_mask_reg <= EXC_MASK_RESET;
			int_mask_reg <= INT_MASK_RESET;
		end else if (wr_en) begin
			unique case (PADDR_IN)
				OFS_CTRL: ctrl_reg <= PWDATA_IN[1:0];
				OFS_EXC_MASK: exc_mask_reg <= PWDATA_IN[FLAG_W-1:0];
				OFS_INT_MASK: int_mask_reg <= PWDATA_IN[INT_W-1:0];
				default: ;
			endcase
		end
	end

	// Read data sampled in setup so it stands through the access phase
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			prdata_reg <= 32'h0;
		end else if (setup) begin
			unique case (PADDR_IN)
				OFS_CTRL: prdata_reg <= {30'h0, ctrl_reg};
				OFS_EXC_MASK: prdata_reg <= {26'h0, exc_mask_reg};
				OFS_FP_STATUS: prdata_reg <= {24'h0, es, 1'b0, flags_reg};
				OFS_FAULT_IP: prdata_reg <= fault_ip_reg;
				OFS_INT_STATUS: prdata_reg <= {28'h0, int_status_reg};
				OFS_INT_MASK: prdata_reg <= {28'h0, int_mask_reg};
				default: prdata_reg <= 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	AST_LEGACY_PIN: assert property (
		@(posedge CLK_IN) disable iff (!RST_B_IN)
		(!native && es && !ignore && !ctrl_reg[CTRL_DEFER_BIT]) |=>
		!FP_ERROR_OUT_N)
		else $error("Error pin not asserted in legacy mode");
	AST_PIN_NO_TRAP: assert property (
		@(posedge CLK_IN) disable iff (!RST_B_IN)
		!native |=> !TRAP_OUT)
		else $error("Internal trap taken in pin mode");
	AST_NATIVE_NO_PIN: assert property (
		@(posedge CLK_IN) disable iff (!RST_B_IN)
		native |=> FP_ERROR_OUT_N)
		else $error("Error pin driven in native mode");
	AST_NATIVE_TRAP: assert property (
		@(posedge CLK_IN) disable iff (!RST_B_IN)
		(waits && es && native && !TRAP_OUT) |=>
		TRAP_OUT && TRAP_VECTOR_OUT == FP_ERROR_VECTOR)
		else $error("Native trap missing");
	AST_TRAP_PULSE: assert property (
		@(posedge CLK_IN) disable iff (!RST_B_IN)
		TRAP_OUT |=> !TRAP_OUT)
		else $error("Trap pulse longer than one cycle");
	AST_FLAG_SET: assert property (
		@(posedge CLK_IN) disable iff (!RST_B_IN)
		exc_unmasked |=> es && flags_reg[INT_EXC_BIT+:FLAG_W] != '0)
		else $error("Summary not set after unmasked exception");
	AST_SET_WINS: assert property (
		@(posedge CLK_IN) disable iff (!RST_B_IN)
		EXC_VALID_IN |=>
		(flags_reg & $past(EXC_FLAGS_IN)) == $past(EXC_FLAGS_IN))
		else $error("Reported flag lost to a clear");
	// Once armed the pin may follow the summary at any time
	AST_DEFER: assert property (
		@(posedge CLK_IN) disable iff (!RST_B_IN)
		(ctrl_reg[CTRL_DEFER_BIT] && !armed_reg && FP_ERROR_OUT_N &&
		!waits) |=> FP_ERROR_OUT_N)
		else $error("Deferred error pin asserted early");
	AST_DEFER_ARM: assert property (
		@(posedge CLK_IN) disable iff (!RST_B_IN)
		(ctrl_reg[CTRL_DEFER_BIT] && !native && es && !ignore && waits)
		|=> !FP_ERROR_OUT_N)
		else $error("Deferred error pin missing at waiting instruction");
	AST_STALL: assert property (
		@(posedge CLK_IN) disable iff (!RST_B_IN)
		(waits && es && !native && !ignore) |-> INSTR_STALL_OUT)
		else $error("Waiting instruction not frozen");
	AST_NOWAIT: assert property (
		@(posedge CLK_IN) disable iff (!RST_B_IN)
		(INSTR_VALID_IN && INSTR_CLASS_IN[2]) |->
		!INSTR_STALL_OUT ##1 !TRAP_OUT)
		else $error("Non-waiting instruction checked");
	AST_CLEAR_NOWAIT: assert property (
		@(posedge CLK_IN) disable iff (!RST_B_IN)
		(clears && !EXC_VALID_IN) |=> flags_reg == '0)
		else $error("Non-waiting clear left flags set");
	AST_IRQ_SEEN: assert property (
		@(posedge CLK_IN) disable iff (!RST_B_IN)
		int_event[INT_IRQ_BIT] |=> int_status_reg[INT_IRQ_BIT])
		else $error("Interrupt request edge not recorded");
	AST_IGNORE: assert property (
		@(posedge CLK_IN) disable iff (!RST_B_IN)
		ignore |-> !INSTR_STALL_OUT ##1 FP_ERROR_OUT_N)
		else $error("Errors reported while ignored");
	AST_SINGLE_LP: assert property (
		@(posedge CLK_IN) disable iff (!RST_B_IN)
		SINGLE_LP_ONLY_OUT == !ctrl_reg[CTRL_NE_BIT])
		else $error("Single processor limit wrong");
	AST_RET_IP: assert property (
		@(posedge CLK_IN) disable iff (!RST_B_IN)
		$rose(TRAP_OUT) |-> TRAP_RETURN_IP_OUT == $past(INSTR_IP_IN))
		else $error("Return pointer not the later instruction");
	AST_FAULT_IP: assert property (
		@(posedge CLK_IN) disable iff (!RST_B_IN)
		exc_unmasked |=> fault_ip_reg == $past(EXC_IP_IN))
		else $error("Faulting pointer not kept");
	AST_PIN_CLEAR: assert property (
		@(posedge CLK_IN) disable iff (!RST_B_IN)
		!es |=> FP_ERROR_OUT_N)
		else $error("Error pin stuck after clear");

	COV_LEGACY_FREEZE: cover property (@(posedge CLK_IN)
		disable iff (!RST_B_IN) !FP_ERROR_OUT_N ##1 INSTR_STALL_OUT);
	COV_NATIVE_TRAP: cover property (@(posedge CLK_IN)
		disable iff (!RST_B_IN) TRAP_OUT);
	COV_IGNORED: cover property (@(posedge CLK_IN)
		disable iff (!RST_B_IN) es && ignore && waits);
	COV_IRQ: cover property (@(posedge CLK_IN)
		disable iff (!RST_B_IN) IRQ_OUT);
	COV_DEFERRED: cover property (@(posedge CLK_IN)
		disable iff (!RST_B_IN) ctrl_reg[CTRL_DEFER_BIT] && !FP_ERROR_OUT_N);
endmodule : fp_err_signal

`default_nettype wire

/* verification/fp_err_glue_model.sv */
// Glue logic and cascaded interrupt controller beside the error pin
`timescale 1ns/1ps
`default_nettype none

module fp_err_glue_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Pins
	input wire logic fp_error_n_in,
	input wire logic service_in,
	output logic irq_out,
	output logic [7:0] vector_out,
	output logic ignore_n_out
);
	// Controller line thirteen follows the error pin, vector 75h
	logic [7:0] vector_reg;
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			irq_out <= 1'b0;
			vector_reg <= 8'h00;
		end else begin
			irq_out <= !fp_error_n_in;
			vector_reg <= !fp_error_n_in ? 8'h75 : 8'h00;
		end
	end
	assign vector_out = vector_reg;
	// Handler service masks further reports
	assign ignore_n_out = !service_in;
endmodule : fp_err_glue_model

`default_nettype wire

/* verification/fp_err_signal_tb.sv */
// Self-checking bench for the floating-point error reporting unit
`timescale 1ns/1ps
`default_nettype none

module fp_err_signal_tb;
	import fp_err_pkg::*;
	logic clk, rst_b, psel, pen, pwr, ev, iv, svc, irq, ign_n;
	logic [7:0] pa;
	logic [31:0] pwd, prd, eip, iip, rd;
	logic [5:0] ef;
	logic [2:0] ic;
	logic pready, pslverr, stall, trap, err_n, single, irq_o;
	logic [7:0] tvec, vec;
	logic [31:0] tip;
	int miscompares = 0;
	int n_checks = 0;

	fp_err_signal u_fp_err_signal (.CLK_IN(clk), .RST_B_IN(rst_b),
		.PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa),
		.PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr), .EXC_VALID_IN(ev), .EXC_FLAGS_IN(ef),
		.EXC_IP_IN(eip), .INSTR_VALID_IN(iv), .INSTR_CLASS_IN(ic),
		.INSTR_IP_IN(iip), .INSTR_STALL_OUT(stall), .TRAP_OUT(trap),
		.TRAP_VECTOR_OUT(tvec), .TRAP_RETURN_IP_OUT(tip),
		.FP_ERROR_OUT_N(err_n), .IGNORE_NUMERIC_ERROR_IN_N(ign_n),
		.MASKABLE_IRQ_IN(irq), .SINGLE_LP_ONLY_OUT(single),
		.IRQ_OUT(irq_o));
	fp_err_glue_model u_fp_err_glue_model (.clk_in(clk), .rst_b_in(rst_b),
		.fp_error_n_in(err_n), .service_in(svc), .irq_out(irq),
		.vector_out(vec), .ignore_n_out(ign_n));

	////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic tally_and_finish();
		if (miscompares == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish

	// Waits on pready as long as it takes; the watchdog ends a hang
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		r = prd;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		logic e;
		apb(1'b0, a, 32'h0, rd, e);
		chk(rd, x);
		chk(e, 1'b0);
	endtask : rdc

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic e;
		apb(1'b1, a, d, rd, e);
	endtask : wr

	task automatic exc(input logic [5:0] f, input logic [31:0] ip);
		@(posedge clk);
		ev <= 1'b1;
		ef <= f;
		eip <= ip;
		@(posedge clk);
		ev <= 1'b0;
	endtask : exc

	task automatic ins(input logic v, input logic [2:0] c, input logic [31:0] ip);
		@(posedge clk);
		iv <= v;
		ic <= c;
		iip <= ip;
		#1;
	endtask : ins

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	////////////////////////////////////////////////////////////////////
	initial begin
		logic e;
		{psel, pen, pwr, ev, iv, svc, rst_b} = '0;
		{pa, pwd, eip, iip, ef, ic} = '0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		rdc(OFS_CTRL, 32'h0);
		rdc(OFS_EXC_MASK, 32'h3f);
		rdc(OFS_INT_MASK, 32'h0);
		chk(err_n, 1'b1);
		chk(irq_o, 1'b0);
		chk(single, 1'b1);
		apb(1'b0, 8'h40, 32'h0, rd, e);
		chk(e, 1'b1);
		// Pin mode: report, freeze, ignore, clear
		wr(OFS_EXC_MASK, 32'h0);
		exc(6'h04, 32'h0000_1234);
		step(1);
		chk(err_n, 1'b0);
		rdc(OFS_FP_STATUS, 32'h84);
		wr(OFS_FAULT_IP, 32'h0);
		rdc(OFS_FAULT_IP, 32'h0000_1234);
		rdc(OFS_INT_STATUS, 32'h7);
		chk(vec, 8'h75);
		ins(1'b1, CLS_WAIT, 32'h20);
		chk(stall, 1'b1);
		ins(1'b1, CLS_STORE_NOWAIT, 32'h24);
		chk(stall, 1'b0);
		ins(1'b1, CLS_FP_WAITING, 32'h28);
		chk(trap, 1'b0);
		@(posedge clk);
		svc <= 1'b1;
		step(4);
		chk(err_n, 1'b1);
		chk(stall, 1'b0);
		chk(vec, 8'h00);
		@(posedge clk);
		svc <= 1'b0;
		step(4);
		chk(err_n, 1'b0);
		ins(1'b1, CLS_CLEX_NOWAIT, 32'h2c);
		ins(1'b0, CLS_OTHER, 32'h0);
		step(2);
		chk(err_n, 1'b1);
		rdc(OFS_FP_STATUS, 32'h0);
		wr(OFS_INT_MASK, 32'h1);
		step(1);
		chk(irq_o, 1'b1);
		wr(OFS_INT_STATUS, 32'hf);
		step(1);
		chk(irq_o, 1'b0);
		// Native mode traps on vector sixteen
		wr(OFS_CTRL, 32'h1);
		step(1);
		chk(single, 1'b0);
		exc(6'h01, 32'h0000_5678);
		ins(1'b1, CLS_FP_WAITING, 32'h0000_9abc);
		chk(stall, 1'b1);
		step(1);
		chk(trap, 1'b1);
		chk(tvec, 8'h10);
		chk(tip, 32'h0000_9abc);
		chk(err_n, 1'b1);
		ins(1'b0, CLS_OTHER, 32'h0);
		rdc(OFS_FAULT_IP, 32'h0000_5678);
		wr(OFS_FP_STATUS, 32'h3f);
		// Deferred pin waits for a waiting instruction
		wr(OFS_CTRL, 32'h2);
		exc(6'h02, 32'h40);
		step(3);
		chk(err_n, 1'b1);
		ins(1'b1, CLS_SIMD, 32'h44);
		step(2);
		chk(err_n, 1'b0);
		ins(1'b1, CLS_INIT_NOWAIT, 32'h48);
		ins(1'b0, CLS_OTHER, 32'h0);
		step(2);
		chk(err_n, 1'b1);
		tally_and_finish();
	end

	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		tally_and_finish();
	end
endmodule : fp_err_signal_tb

`default_nettype wire
